//--- shared/sab_pkg.sv
// constants, carrier structs and state types of the auto-buffered serial port
// assumes one machine clock domain; serial pins are resynchronised inside the port
package sab_pkg;

  // data, memory and counter widths
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 16;
  localparam int OFF_W   = 11;
  localparam int DIV_W   = 8;
  localparam int FSP_W   = 8;
  localparam int CNT_W   = 4;

  // fixed 2K-word window of internal memory reachable by the buffering unit
  localparam int                REGION_WORDS = 2048;
  localparam logic [ADDR_W-1:0] REGION_BASE  = 16'h0800;

  // timing: own clock and the far end's serial clock limit
  localparam int CLOCK_PERIOD_PS     = 4000;
  localparam int MACHINE_CYCLE_PS    = 25000;
  localparam int SER_MIN_PERIOD_CYC  = (MACHINE_CYCLE_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;
  localparam logic [DIV_W-1:0]  DIV_RST  = 8'h00;
  localparam logic [FSP_W-1:0]  FSP_RST  = 8'h00;
  localparam logic [OFF_W-1:0]  OFF_RST  = 11'h000;

  // packet lengths
  typedef enum logic [1:0] {
    SAB_LEN8  = 2'h0,
    SAB_LEN10 = 2'h1,
    SAB_LEN12 = 2'h2,
    SAB_LEN16 = 2'h3
  } sab_len_type;

  // serial shifter states, gray along idle -> armed -> shift
  typedef enum logic [1:0] {
    SAB_IDLE  = 2'h0,
    SAB_ARMED = 2'h1,
    SAB_SHIFT = 2'h3
  } sab_state_type;

  // serial core configuration
  typedef struct packed {
    sab_len_type      wordLen;
    logic             continuous;
    logic             clkPolarity;
    logic             fsPolarity;
    logic             clkInternal;
    logic             fsInternal;
    logic [DIV_W-1:0] clkDivide;
    logic [FSP_W-1:0] fsPeriod;
    logic             pcmMode;
  } sab_cfg_type;

  // per-direction buffering setup
  typedef struct packed {
    logic             autoEn;
    logic             autoDisable;
    logic [OFF_W-1:0] start;
    logic [OFF_W-1:0] length;
  } sab_abu_type;

  // memory request toward internal memory
  typedef struct packed {
    logic              req;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sab_mem_type;

  // index of the last bit of a packet
  function automatic logic [CNT_W-1:0] sab_last_bit(input sab_len_type l);
    case (l)
      SAB_LEN8:  sab_last_bit = 4'h7;
      SAB_LEN10: sab_last_bit = 4'h9;
      SAB_LEN12: sab_last_bit = 4'hB;
      default:   sab_last_bit = 4'hF;
    endcase
  endfunction

endpackage

//--- rtl/sab_addr_gen.sv
// circular address generator of the buffering unit, one per direction
// assumes restart and step are single-cycle pulses on the machine clock
`timescale 1ns/1ps
module sab_addr_gen #(
  parameter int OFF_W = 11
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // control
  input  wire logic             restart,
  input  wire logic             step,
  input  wire logic [OFF_W-1:0] start,
  input  wire logic [OFF_W-1:0] length,
  // result
  output logic      [OFF_W-1:0] offset,
  output logic                  boundary
);
  import sab_pkg::*;

  logic [OFF_W-1:0] count_r;
  logic [OFF_W-1:0] count_nxt;
  logic [OFF_W-1:0] offset_r;
  logic [OFF_W-1:0] offset_nxt;

  // length zero wraps to the full window
  assign boundary = (count_r == OFF_W'(length - 1'b1)); // RQ3
  assign offset   = offset_r;

  always_comb begin
    count_nxt  = count_r;
    offset_nxt = offset_r;
    if (restart) begin
      count_nxt  = '0;
      offset_nxt = start;
    end else if (step) begin
      if (boundary) begin // RQ3
        count_nxt  = '0;
        offset_nxt = start;
      end else begin
        count_nxt  = OFF_W'(count_r + 1'b1);
        offset_nxt = OFF_W'(offset_r + 1'b1); // RQ4
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_r  <= '0;
      offset_r <= '0;
    end else begin
      count_r  <= count_nxt;
      offset_r <= offset_nxt;
    end
  end

endmodule

//--- rtl/sab_serial_port.sv
// buffered serial port: full-duplex serial core with an auto-buffering unit
// assumes serial pins are asynchronous to clock; memory answers a held req with a one-cycle ack
//
// Summary of operation
// RQ1: with buffering off, each word event goes straight to the cpu as its transmit or receive interrupt.
// RQ2: with buffering on, words move between the serial core and memory with no cpu involvement.
// RQ3: the buffering unit keeps its own circular address registers and generators per direction.
// RQ4: buffered transfers only address a fixed 2K-word window at programmed start and length.
// RQ5: an interrupt is raised when a transmit buffer is emptied or a receive buffer is filled.
// RQ6: with auto-disable selected, buffering stops by itself at the buffer boundary.
// RQ7: transmit and receive buffering have separate enables.
// RQ8: packets are 8, 10, 12 or 16 bits as software selects, matching the far end.
// RQ9: in burst mode every packet is preceded by its own frame pulse.
// RQ10: in continuous mode one frame pulse starts the stream and later packets follow back to back.
// RQ11: serial clock and frame pulse have programmable rate and polarity.
// RQ12: the core is static and holds its state at any serial clock rate, even when stopped.
// RQ13: an external serial clock never runs faster than the machine-cycle clock.
// RQ14: the transmitter has a pcm mode that releases the line outside packets.
// RQ15: transmit and receive are full duplex and each double-buffered.
// RQ16: at the boundary with auto-disable the enable clears in the cycle the buffer interrupt rises.
`timescale 1ns/1ps
module sab_serial_port (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  // configuration
  input  wire sab_pkg::sab_cfg_type        cfg,
  input  wire sab_pkg::sab_abu_type        txAbu,
  input  wire sab_pkg::sab_abu_type        rxAbu,
  // cpu side
  input  wire logic [sab_pkg::DATA_W-1:0]  txWord,
  input  wire logic                        txWrite,
  input  wire logic                        rxRead,
  output logic      [sab_pkg::DATA_W-1:0]  rxWord,
  output logic                             txHoldEmpty,
  output logic                             rxHoldFull,
  output logic                             txAutoActive,
  output logic                             rxAutoActive,
  output logic                             cpuTransmitInterrupt,
  output logic                             cpuReceiveInterrupt,
  // internal memory
  output sab_pkg::sab_mem_type             mem,
  input  wire logic                        memAck,
  input  wire logic [sab_pkg::DATA_W-1:0]  memRdata,
  // serial pins
  input  wire logic                        serClkIn,
  output logic                             serClkOut,
  input  wire logic                        frameSyncIn,
  output logic                             frameSyncOut,
  input  wire logic                        rxDataIn,
  output logic                             txDataOut,
  output logic                             txDataOe
);
  import sab_pkg::*;

  // pin resynchronisers
  logic [1:0] clkSync_r, fsSync_r, rxSync_r;
  logic [1:0] clkSync_nxt, fsSync_nxt, rxSync_nxt;

  // clock and frame generation
  logic [DIV_W-1:0] divCnt_r, divCnt_nxt;
  logic             intClk_r, intClk_nxt;
  logic             effPrev_r, effPrev_nxt;
  logic [FSP_W-1:0] fsCnt_r, fsCnt_nxt;
  logic             fsGen_r, fsGen_nxt;
  logic             effClk, driveEdge, sampleEdge, fsActive;

  // transmit path
  sab_state_type     txState_r, txState_nxt;
  logic [DATA_W-1:0] txHold_r, txHold_nxt, txShift_r, txShift_nxt;
  logic              txFull_r, txFull_nxt;
  logic [CNT_W-1:0]  txCnt_r, txCnt_nxt;
  logic              wordTransmitEvent;
  logic              txLoad;

  // receive path
  sab_state_type     rxState_r, rxState_nxt;
  logic [DATA_W-1:0] rxHold_r, rxHold_nxt, rxShift_r, rxShift_nxt;
  logic              rxFull_r, rxFull_nxt;
  logic [CNT_W-1:0]  rxCnt_r, rxCnt_nxt;
  logic              wordReceiveEvent;

  // buffering unit
  sab_mem_type       mem_r, mem_nxt;
  logic              txAct_r, txAct_nxt, rxAct_r, rxAct_nxt;
  logic              txEnPrev_r, rxEnPrev_r;
  logic              txInt_r, txInt_nxt, rxInt_r, rxInt_nxt;
  logic              txRestart, rxRestart, txStep, rxStep, txBound, rxBound;
  logic [OFF_W-1:0]  txOff, rxOff;
  logic [CNT_W-1:0]  lastBit;
  logic [DATA_W-1:0] rxWordIn;

  assign lastBit = sab_last_bit(cfg.wordLen); // RQ8

  // only the second stage of each synchroniser is read
  always_comb begin
    clkSync_nxt = {clkSync_r[0], serClkIn};
    fsSync_nxt  = {fsSync_r[0], frameSyncIn};
    rxSync_nxt  = {rxSync_r[0], rxDataIn};
  end

  // edge detection on whichever clock is chosen; switching source may give one stray edge
  assign effClk     = (cfg.clkInternal ? intClk_r : clkSync_r[1]) ^ cfg.clkPolarity; // RQ11
  assign driveEdge  = effClk & ~effPrev_r; // RQ12
  assign sampleEdge = ~effClk & effPrev_r;
  assign fsActive   = cfg.fsInternal ? fsGen_r : (fsSync_r[1] ^ cfg.fsPolarity); // RQ11

  always_comb begin
    divCnt_nxt  = divCnt_r;
    intClk_nxt  = intClk_r;
    fsCnt_nxt   = fsCnt_r;
    fsGen_nxt   = fsGen_r;
    effPrev_nxt = effClk;
    if (divCnt_r >= cfg.clkDivide) begin // RQ11
      divCnt_nxt = DIV_RST;
      intClk_nxt = ~intClk_r;
    end else begin
      divCnt_nxt = DIV_W'(divCnt_r + 1'b1);
    end
    if (driveEdge) begin
      fsGen_nxt = (fsCnt_r == FSP_RST); // RQ11
      fsCnt_nxt = (fsCnt_r >= cfg.fsPeriod) ? FSP_RST : FSP_W'(fsCnt_r + 1'b1);
    end
  end

  assign serClkOut    = intClk_r ^ cfg.clkPolarity;
  assign frameSyncOut = fsGen_r ^ cfg.fsPolarity;

  // transmit shifter: frame seen on a sample edge, first bit driven on the next drive edge
  assign txLoad = driveEdge & txFull_r &
                  ((txState_r == SAB_ARMED) |
                   ((txState_r == SAB_SHIFT) & (txCnt_r == CNT_RST) & cfg.continuous)); // RQ10
  assign wordTransmitEvent = txLoad;

  always_comb begin
    txState_nxt = txState_r;
    txShift_nxt = txShift_r;
    txCnt_nxt   = txCnt_r;
    if (sampleEdge & fsActive & (txState_r == SAB_IDLE)) begin
      txState_nxt = SAB_ARMED; // RQ9
    end
    if (txLoad) begin
      txShift_nxt = txHold_r << (4'hF - lastBit); // RQ15
      txCnt_nxt   = lastBit;
      txState_nxt = SAB_SHIFT;
    end else if (driveEdge) begin
      case (txState_r)
        SAB_ARMED: txState_nxt = SAB_IDLE;
        SAB_SHIFT: begin
          if (txCnt_r == CNT_RST) begin
            txState_nxt = SAB_IDLE; // RQ9
          end else begin
            txShift_nxt = {txShift_r[DATA_W-2:0], 1'b0};
            txCnt_nxt   = CNT_W'(txCnt_r - 1'b1);
          end
        end
        default: txState_nxt = txState_r;
      endcase
    end
  end

  assign txDataOut = txShift_r[DATA_W-1];
  assign txDataOe  = cfg.pcmMode ? (txState_r == SAB_SHIFT) : 1'b1; // RQ14

  // receive shifter: first bit taken on the sample edge after the frame pulse
  assign rxWordIn         = {rxShift_r[DATA_W-2:0], rxSync_r[1]};
  assign wordReceiveEvent = sampleEdge & (rxState_r == SAB_ARMED) & (rxCnt_r == CNT_RST);

  always_comb begin
    rxState_nxt = rxState_r;
    rxShift_nxt = rxShift_r;
    rxCnt_nxt   = rxCnt_r;
    if (sampleEdge) begin
      case (rxState_r)
        SAB_IDLE: begin
          if (fsActive) begin
            rxState_nxt = SAB_ARMED; // RQ9
            rxCnt_nxt   = lastBit;
            rxShift_nxt = DATA_RST;
          end
        end
        SAB_ARMED: begin
          rxShift_nxt = rxWordIn;
          if (rxCnt_r == CNT_RST) begin
            rxState_nxt = cfg.continuous ? SAB_ARMED : SAB_IDLE; // RQ10
            rxCnt_nxt   = lastBit;
            rxShift_nxt = DATA_RST;
          end else begin
            rxCnt_nxt = CNT_W'(rxCnt_r - 1'b1);
          end
        end
        default: rxState_nxt = SAB_IDLE;
      endcase
    end
  end

  // buffering unit: one memory request at a time, receive stores first
  assign txRestart = txAbu.autoEn & ~txEnPrev_r; // RQ7
  assign rxRestart = rxAbu.autoEn & ~rxEnPrev_r;
  assign txStep    = memAck & mem_r.req & ~mem_r.write;
  assign rxStep    = memAck & mem_r.req & mem_r.write;

  always_comb begin
    mem_nxt    = mem_r;
    txHold_nxt = txHold_r;
    txFull_nxt = txFull_r & ~txLoad;
    rxHold_nxt = rxHold_r;
    rxFull_nxt = rxFull_r;
    txAct_nxt  = (txAct_r | txRestart) & txAbu.autoEn; // RQ7
    rxAct_nxt  = (rxAct_r | rxRestart) & rxAbu.autoEn;
    txInt_nxt  = txAct_r ? (txStep & txBound) : wordTransmitEvent; // RQ1 RQ5
    rxInt_nxt  = rxAct_r ? (rxStep & rxBound) : wordReceiveEvent;  // RQ1 RQ5
    if ((rxAct_r & rxRead) | (~rxAct_r & rxRead) | rxStep) begin
      rxFull_nxt = 1'b0;
    end
    if (wordReceiveEvent) begin
      rxHold_nxt = rxWordIn; // RQ15
      rxFull_nxt = 1'b1;
    end
    if (~txAct_r & txWrite) begin
      txHold_nxt = txWord;
      txFull_nxt = 1'b1;
    end
    if (mem_r.req) begin
      if (memAck) begin
        mem_nxt.req = 1'b0;
        if (txStep) begin
          txHold_nxt = memRdata; // RQ2
          txFull_nxt = 1'b1;
          if (txBound & txAbu.autoDisable) txAct_nxt = 1'b0; // RQ6 RQ16
        end
        if (rxStep & rxBound & rxAbu.autoDisable) rxAct_nxt = 1'b0; // RQ6 RQ16
      end
    end else if (rxAct_r & rxFull_r) begin
      mem_nxt.req   = 1'b1; // RQ2
      mem_nxt.write = 1'b1;
      mem_nxt.addr  = REGION_BASE | ADDR_W'(rxOff); // RQ4
      mem_nxt.wdata = rxHold_r;
    end else if (txAct_r & ~txFull_r) begin
      mem_nxt.req   = 1'b1; // RQ2
      mem_nxt.write = 1'b0;
      mem_nxt.addr  = REGION_BASE | ADDR_W'(txOff); // RQ4
    end
  end

  sab_addr_gen #(.OFF_W(OFF_W)) txGen (
    .clock    (clock),
    .reset_n  (reset_n),
    .restart  (txRestart),
    .step     (txStep),
    .start    (txAbu.start),
    .length   (txAbu.length),
    .offset   (txOff),
    .boundary (txBound)
  );

  sab_addr_gen #(.OFF_W(OFF_W)) rxGen (
    .clock    (clock),
    .reset_n  (reset_n),
    .restart  (rxRestart),
    .step     (rxStep),
    .start    (rxAbu.start),
    .length   (rxAbu.length),
    .offset   (rxOff),
    .boundary (rxBound)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clkSync_r  <= 2'h0;
      fsSync_r   <= 2'h0;
      rxSync_r   <= 2'h0;
      divCnt_r   <= DIV_RST;
      intClk_r   <= 1'b0;
      effPrev_r  <= 1'b0;
      fsCnt_r    <= FSP_RST;
      fsGen_r    <= 1'b0;
      txState_r  <= SAB_IDLE;
      txShift_r  <= DATA_RST;
      txCnt_r    <= CNT_RST;
      txHold_r   <= DATA_RST;
      txFull_r   <= 1'b0;
      rxState_r  <= SAB_IDLE;
      rxShift_r  <= DATA_RST;
      rxCnt_r    <= CNT_RST;
      rxHold_r   <= DATA_RST;
      rxFull_r   <= 1'b0;
      mem_r      <= '0;
      txAct_r    <= 1'b0;
      rxAct_r    <= 1'b0;
      txEnPrev_r <= 1'b0;
      rxEnPrev_r <= 1'b0;
      txInt_r    <= 1'b0;
      rxInt_r    <= 1'b0;
    end else begin
      clkSync_r  <= clkSync_nxt;
      fsSync_r   <= fsSync_nxt;
      rxSync_r   <= rxSync_nxt;
      divCnt_r   <= divCnt_nxt;
      intClk_r   <= intClk_nxt;
      effPrev_r  <= effPrev_nxt;
      fsCnt_r    <= fsCnt_nxt;
      fsGen_r    <= fsGen_nxt;
      txState_r  <= txState_nxt;
      txShift_r  <= txShift_nxt;
      txCnt_r    <= txCnt_nxt;
      txHold_r   <= txHold_nxt;
      txFull_r   <= txFull_nxt;
      rxState_r  <= rxState_nxt;
      rxShift_r  <= rxShift_nxt;
      rxCnt_r    <= rxCnt_nxt;
      rxHold_r   <= rxHold_nxt;
      rxFull_r   <= rxFull_nxt;
      mem_r      <= mem_nxt;
      txAct_r    <= txAct_nxt;
      rxAct_r    <= rxAct_nxt;
      txEnPrev_r <= txAbu.autoEn;
      rxEnPrev_r <= rxAbu.autoEn;
      txInt_r    <= txInt_nxt;
      rxInt_r    <= rxInt_nxt;
    end
  end

  assign mem                  = mem_r;
  assign rxWord               = rxHold_r;
  assign txHoldEmpty          = ~txFull_r;
  assign rxHoldFull           = rxFull_r;
  assign txAutoActive         = txAct_r;
  assign rxAutoActive         = rxAct_r;
  assign cpuTransmitInterrupt = txInt_r;
  assign cpuReceiveInterrupt  = rxInt_r;

endmodule

//--- tb/sab_serial_port_sva.sv
// checker of the auto-buffered serial port, sees only the top ports
// assumes one machine clock domain and the memory handshake of the port
`timescale 1ns/1ps
module sab_serial_port_sva (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 reset_n,
  // watched ports
  input wire sab_pkg::sab_cfg_type cfg,
  input wire logic                 txAutoActive,
  input wire logic                 rxAutoActive,
  input wire logic                 cpuTransmitInterrupt,
  input wire logic                 cpuReceiveInterrupt,
  input wire sab_pkg::sab_mem_type mem,
  input wire logic                 memAck,
  input wire logic                 txDataOe
);
  import sab_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_tx_pulse; cpuTransmitInterrupt |=> !cpuTransmitInterrupt; endproperty
  property p_rx_pulse; cpuReceiveInterrupt |=> !cpuReceiveInterrupt; endproperty
  property p_req_hold; mem.req && !memAck |=> mem.req && $stable(mem.addr) && $stable(mem.write); endproperty
  property p_req_done; mem.req && memAck |=> !mem.req; endproperty
  property p_region; mem.req |-> mem.addr[15:11] == 5'h01; endproperty
  property p_rd_tx; mem.req && !mem.write |-> txAutoActive; endproperty
  property p_wr_rx; mem.req && mem.write |-> rxAutoActive; endproperty
  property p_tx_stop; $fell(txAutoActive) |-> cpuTransmitInterrupt; endproperty
  property p_rx_stop; $fell(rxAutoActive) |-> cpuReceiveInterrupt; endproperty
  property p_oe; !cfg.pcmMode |-> txDataOe; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx interrupt longer than one cycle");
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx interrupt longer than one cycle");
  a_req_hold: assert property (p_req_hold) else $error("memory request changed before ack");
  a_req_done: assert property (p_req_done) else $error("memory request kept after ack");
  a_region: assert property (p_region) else $error("memory address outside window");
  a_rd_tx: assert property (p_rd_tx) else $error("fetch without tx buffering");
  a_wr_rx: assert property (p_wr_rx) else $error("store without rx buffering");
  a_tx_stop: assert property (p_tx_stop) else $error("tx buffering stopped without interrupt");
  a_rx_stop: assert property (p_rx_stop) else $error("rx buffering stopped without interrupt");
  a_oe: assert property (p_oe) else $error("tx line released outside pcm mode");
  c_tx_int: cover property (cpuTransmitInterrupt && !txAutoActive);
  c_store: cover property (mem.req && mem.write && memAck);
  c_stop: cover property ($fell(rxAutoActive));
endmodule

bind sab_serial_port sab_serial_port_sva u_sva (
  .clock(clock),
  .reset_n(reset_n),
  .cfg(cfg),
  .txAutoActive(txAutoActive),
  .rxAutoActive(rxAutoActive),
  .cpuTransmitInterrupt(cpuTransmitInterrupt),
  .cpuReceiveInterrupt(cpuReceiveInterrupt),
  .mem(mem),
  .memAck(memAck),
  .txDataOe(txDataOe)
);

//--- tb/sab_codec_model.sv
// behavioural codec at the far end of the serial pins
// assumes burst framing; clock stands still between packets
`timescale 1ns/1ps
module sab_codec_model (
  // polarity setup
  input wire logic clkPol,
  input wire logic fsPol,
  // serial pins
  output logic     serClk,
  output logic     frameSync,
  output logic     rxData,
  input wire logic txData
);
  logic clkRaw;
  logic fsRaw;
  assign serClk = clkRaw ^ clkPol;
  assign frameSync = fsRaw ^ fsPol;
  initial begin
    clkRaw = 1'b0;
    fsRaw = 1'b0;
    rxData = 1'b0;
  end
  // one packet with its own frame, msb first, 125 ns bit period
  task automatic packet(input logic [15:0] word, input int nBits, input bit stall, output logic [15:0] got);
    got = 16'h0000;
    fsRaw = 1'b1;
    clkRaw = 1'b1;
    #62.5 clkRaw = 1'b0;
    for (int i = nBits - 1; i >= 0; i--) begin
      #62.5 clkRaw = 1'b1;
      fsRaw = 1'b0;
      rxData = word[i];
      // a stopped clock mid-packet must not lose state
      if (stall && i == 3) #2000;
      #62.5 clkRaw = 1'b0;
      got = {got[14:0], txData};
    end
    #62.5 clkRaw = 1'b1;
    #62.5 clkRaw = 1'b0;
    // released line shows no stale bit
    rxData = ~rxData;
  endtask
endmodule

//--- tb/test_sab_serial_port.sv
// self-checking bench of the auto-buffered serial port
// assumes the codec model above and a one-cycle-ack memory answering here
`timescale 1ns/1ps
module test_sab_serial_port;
  import sab_pkg::*;
  typedef struct packed {
    sab_len_type len;
    logic        pol;
    logic        stall;
    logic [15:0] tx;
    logic [15:0] rx;
  } sab_row_type;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  sab_cfg_type cfg = '0;
  sab_abu_type txAbu = '0;
  sab_abu_type rxAbu = '0;
  logic [15:0] txWord = 16'h0000;
  logic        txWrite = 1'b0;
  logic        rxRead = 1'b0;
  logic [15:0] rxWord;
  logic        txHoldEmpty, rxHoldFull, txAutoActive, rxAutoActive;
  logic        cpuTransmitInterrupt, cpuReceiveInterrupt;
  sab_mem_type mem;
  logic        memAck = 1'b0;
  logic [15:0] memRdata = 16'h0000;
  logic        serClkIn, serClkOut, frameSyncIn, frameSyncOut, rxDataIn, txDataOut, txDataOe;
  int          failures = 0, tests_run = 0, cycles = 0, txInts = 0, rxInts = 0, n = 0;
  logic        lvl;
  logic [15:0] rdA[$], wrA[$], wrD[$], got;
  int          nb[4] = '{8, 10, 12, 16};
  sab_row_type rows[4] = '{'{SAB_LEN8, 1'b0, 1'b0, 16'hFFA5, 16'h003C},
                           '{SAB_LEN10, 1'b1, 1'b0, 16'h0355, 16'h02AA},
                           '{SAB_LEN12, 1'b0, 1'b1, 16'h0F0F, 16'h0963},
                           '{SAB_LEN16, 1'b1, 1'b0, 16'h8001, 16'hC3A5}};

  always #2 clock = ~clock;

  sab_serial_port dut (.clock(clock), .reset_n(reset_n), .cfg(cfg), .txAbu(txAbu), .rxAbu(rxAbu),
    .txWord(txWord), .txWrite(txWrite), .rxRead(rxRead), .rxWord(rxWord), .txHoldEmpty(txHoldEmpty),
    .rxHoldFull(rxHoldFull), .txAutoActive(txAutoActive), .rxAutoActive(rxAutoActive),
    .cpuTransmitInterrupt(cpuTransmitInterrupt), .cpuReceiveInterrupt(cpuReceiveInterrupt), .mem(mem),
    .memAck(memAck), .memRdata(memRdata), .serClkIn(serClkIn), .serClkOut(serClkOut),
    .frameSyncIn(frameSyncIn), .frameSyncOut(frameSyncOut), .rxDataIn(rxDataIn), .txDataOut(txDataOut),
    .txDataOe(txDataOe));

  sab_codec_model u_codec (.clkPol(cfg.clkPolarity), .fsPol(cfg.fsPolarity), .serClk(serClkIn),
    .frameSync(frameSyncIn), .rxData(rxDataIn), .txData(txDataOut));

  // memory: ack one cycle after a request, data derived from the address
  always @(posedge clock) begin
    if (mem.req === 1'b1 && memAck === 1'b1) begin
      if (mem.write) begin
        wrA.push_back(mem.addr);
        wrD.push_back(mem.wdata);
      end else rdA.push_back(mem.addr);
    end
    memAck <= mem.req === 1'b1 && memAck !== 1'b1;
    memRdata <= mem.addr ^ 16'h5A5A;
    if (cpuTransmitInterrupt === 1'b1) txInts++;
    if (cpuReceiveInterrupt === 1'b1) rxInts++;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("BAD cycleLimit expected 0 seen 1");
      stop_test();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  task automatic pulse_write(input logic [15:0] w);
    txWord <= w;
    txWrite <= 1'b1;
    @(posedge clock) txWrite <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    cfg.wordLen = SAB_LEN16;
    repeat (16) @(posedge clock);
    check("rstHoldFull", 16'h0000, {15'h0000, rxHoldFull});
    check("rstReq", 16'h0000, {15'h0000, mem.req});
    check("rstOe", 16'h0001, {15'h0000, txDataOe});
    reset_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      cfg.wordLen <= rows[i].len;
      cfg.clkPolarity <= rows[i].pol;
      cfg.fsPolarity <= rows[i].pol;
      do_reset();
      pulse_write(rows[i].tx);
      check("txHoldFull", 16'h0000, {15'h0000, txHoldEmpty});
      txInts = 0;
      rxInts = 0;
      u_codec.packet(rows[i].rx, nb[rows[i].len], rows[i].stall, got);
      repeat (10) @(posedge clock);
      check("txSerial", rows[i].tx & (16'hFFFF >> (16 - nb[rows[i].len])), got);
      check("txHoldEmpty", 16'h0001, {15'h0000, txHoldEmpty});
      check("rxWord", rows[i].rx & (16'hFFFF >> (16 - nb[rows[i].len])), rxWord);
      check("rxHoldFull", 16'h0001, {15'h0000, rxHoldFull});
      check("txInts", 16'h0001, txInts[15:0]);
      check("rxInts", 16'h0001, rxInts[15:0]);
      rxRead <= 1'b1;
      @(posedge clock) rxRead <= 1'b0;
      repeat (2) @(posedge clock);
      check("rxHoldClear", 16'h0000, {15'h0000, rxHoldFull});
    end
    // both directions buffered, two-word buffers, tx start at the window's top offset
    txAbu <= '{1'b1, 1'b1, 11'h7FF, 11'h002};
    rxAbu <= '{1'b1, 1'b1, 11'h010, 11'h002};
    for (int k = 0; k < 50 && rdA.size() == 0; k++) @(posedge clock);
    repeat (4) @(posedge clock);
    check("txAuto", 16'h0001, {15'h0000, txAutoActive});
    txInts = 0;
    rxInts = 0;
    u_codec.packet(16'h1357, 16, 1'b0, got);
    check("autoTx0", 16'h0FFF ^ 16'h5A5A, got);
    check("autoTxInts", 16'h0001, txInts[15:0]);
    // tx buffering has stopped, so the next word event reaches the cpu as in standard mode
    txInts = 0;
    u_codec.packet(16'h2468, 16, 1'b0, got);
    check("autoTx1", 16'h0800 ^ 16'h5A5A, got);
    repeat (10) @(posedge clock);
    check("rdCount", 16'h0002, rdA.size());
    check("rdAddr1", 16'h0800, rdA[1]);
    check("wrCount", 16'h0002, wrA.size());
    check("wrAddr0", 16'h0810, wrA[0]);
    check("wrAddr1", 16'h0811, wrA[1]);
    check("wrData0", 16'h1357, wrD[0]);
    check("wrData1", 16'h2468, wrD[1]);
    check("stdTxInts", 16'h0001, txInts[15:0]);
    check("autoRxInts", 16'h0001, rxInts[15:0]);
    check("autoOff", 16'h0000, {14'h0000, txAutoActive, rxAutoActive});
    txAbu.autoEn <= 1'b0;
    rxAbu.autoEn <= 1'b0;
    cfg.pcmMode <= 1'b1;
    repeat (4) @(posedge clock);
    check("pcmIdleOe", 16'h0000, {15'h0000, txDataOe});
    // internal clock, one frame at start, then words back to back with no new frame
    cfg.clkInternal <= 1'b1;
    cfg.fsInternal <= 1'b1;
    cfg.continuous <= 1'b1;
    cfg.clkDivide <= 8'h03;
    cfg.fsPeriod <= 8'hFF;
    do_reset();
    txInts = 0;
    pulse_write(16'h1234);
    for (n = 0; n < 40 && txHoldEmpty !== 1'b1; n++) @(posedge clock);
    pulse_write(16'h5678);
    check("pcmShiftOe", 16'h0001, {15'h0000, txDataOe});
    lvl = serClkOut;
    for (n = 0; n < 20 && serClkOut === lvl; n++) @(posedge clock);
    lvl = serClkOut;
    for (n = 0; n < 20 && serClkOut === lvl; n++) @(posedge clock);
    check("clkHalfPeriod", 16'h0004, n[15:0]);
    n = 0;
    repeat (300) begin
      @(posedge clock);
      if (frameSyncOut !== cfg.fsPolarity) n++;
    end
    check("extraFrames", 16'h0000, n[15:0]);
    // burst framing would hold the second word until the next frame, 256 bits away
    check("contTxInts", 16'h0002, txInts[15:0]);
    stop_test();
  end
endmodule
